// >>> hw/rss_supervisor.sv
// reset source supervisor: source combining, reset sequencing and cause register
`include "rss_defines.svh"
`default_nettype none
module rss_supervisor
  import rss_pkg::*;
#(
  parameter int POR_DELAY_CYC = `RSS_POR_DELAY_CYC,
  parameter int MIN_HOLD_CYC = `RSS_MIN_HOLD_CYC
) (
  input wire logic core_clk_i, // 250 MHz system clock
  input wire logic sys_rst_i, // power-on reset, async, active high
  input wire rss_src_t src_i, // reset trigger inputs
  input wire rss_sfr_req_t sfr_i, // register access from the core
  input wire logic flash_wr_req_i, // flash erase or write request
  output logic [7:0] sfr_rdata_o, // register read data
  output logic core_rst_o, // core, registers, interrupts, timers held
  output logic core_start_o, // one-cycle pulse on reset exit
  output logic [15:0] reset_vector_o, // fetch address after exit
  output logic port_rst_o, // ports forced open-drain low-drive
  output logic [7:0] port_latch_init_o, // latch value applied during reset
  output logic weak_pullup_en_o, // weak pullup enable
  output logic rst_pin_o, // reset pin output level
  output logic rst_pin_oe_o, // reset pin driven
  output logic flash_wr_grant_o, // flash erase or write allowed
  output logic vmon_en_o, // supply monitor enable
  output logic mcd_en_o // clock-loss detector enable
);
  localparam int CW = $clog2(POR_DELAY_CYC + 1) + 1;
  localparam logic [CW-1:0] POR_LAST = CW'(POR_DELAY_CYC - 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(MIN_HOLD_CYC - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rss_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [7:0] cause_q, cause_d;
  logic vmon_en_q, vmon_en_d;
  logic vmon_sel_q, vmon_sel_d;
  logic mcd_en_q, mcd_en_d;
  logic cmp_en_q, cmp_en_d;
  logic pin_drv_q, pin_drv_d;
  logic core_rst_q, core_rst_d;
  logic start_q, start_d;
  logic grant_q, grant_d;
  logic [7:0] rdata_q, rdata_d;

  logic vmon_trip, pin_trip, mcd_trip, cmp_trip, any_trip, level_on;
  logic cause_wr, vmon_wr;
  logic [7:0] trip_cause;

  // ----------------------------------------------------------------
  // source detection
  // ----------------------------------------------------------------
  always_comb begin
    vmon_trip = vmon_en_q && vmon_sel_q && src_i.vdd_low;
    pin_trip = !src_i.rst_pin_n;
    mcd_trip = mcd_en_q && src_i.clk_missing;
    cmp_trip = cmp_en_q && !src_i.cmp0_out;
    any_trip = vmon_trip || pin_trip || mcd_trip || cmp_trip || src_i.wdt_ovf
               || src_i.flash_err;
    cause_wr = sfr_i.wr && (sfr_i.addr == `RSS_CAUSE_ADDR);
    vmon_wr = sfr_i.wr && (sfr_i.addr == `RSS_VMON_ADDR);
    // one-hot cause, supply first; the other flags of a power cause read 0
    trip_cause = 8'h00;
    if (vmon_trip) begin
      trip_cause[`RSS_BIT_POR] = 1'b1;
    end else if (pin_trip) begin
      trip_cause[`RSS_BIT_PIN] = 1'b1;
    end else if (mcd_trip) begin
      trip_cause[`RSS_BIT_MCD] = 1'b1;
    end else if (cmp_trip) begin
      trip_cause[`RSS_BIT_CMP] = 1'b1;
    end else if (src_i.wdt_ovf) begin
      trip_cause[`RSS_BIT_WDT] = 1'b1;
    end else if (src_i.flash_err) begin
      trip_cause[`RSS_BIT_FLASH] = 1'b1;
    end else begin
      trip_cause[`RSS_BIT_SW] = 1'b1;
    end
    // the hold lasts while the level source that caused it stays active
    // our own pull on the pin is no new trip: pin causes are only taken in run
    level_on = (cause_q[`RSS_BIT_POR] && src_i.vdd_low)
               || (cause_q[`RSS_BIT_PIN] && !src_i.rst_pin_n);
  end

  // ----------------------------------------------------------------
  // sequencer and registers
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cause_d = cause_q;
    vmon_en_d = vmon_en_q;
    vmon_sel_d = vmon_sel_q;
    mcd_en_d = mcd_en_q;
    cmp_en_d = cmp_en_q;
    pin_drv_d = pin_drv_q;
    start_d = 1'b0;
    unique case (state_q)
      RSS_ST_POR: begin
        cnt_d = cnt_q + CW'(1);
        if (cnt_q >= POR_LAST) begin
          state_d = RSS_ST_RUN;
          cnt_d = '0;
          pin_drv_d = 1'b0;
          start_d = 1'b1;
        end
      end
      RSS_ST_RUN: begin
        if (any_trip || (cause_wr && sfr_i.wdata[`RSS_BIT_SW])) begin
          state_d = RSS_ST_HOLD;
          cnt_d = '0;
          cause_d = trip_cause;
          pin_drv_d = vmon_trip;
          // register reload; monitor enable and selection are kept
          mcd_en_d = 1'b0;
          cmp_en_d = 1'b0;
        end else begin
          if (cause_wr) begin
            // writes go to the enables, never to the flags
            vmon_sel_d = sfr_i.wdata[`RSS_BIT_POR];
            mcd_en_d = sfr_i.wdata[`RSS_BIT_MCD];
            cmp_en_d = sfr_i.wdata[`RSS_BIT_CMP];
          end
          if (vmon_wr) begin
            vmon_en_d = sfr_i.wdata[`RSS_BIT_VMON_EN];
          end
        end
      end
      RSS_ST_HOLD: begin
        if (cnt_q < HOLD_LAST) begin
          cnt_d = cnt_q + CW'(1);
        end else if (!level_on) begin
          // no power-on delay here, even after a supply reset
          state_d = RSS_ST_RUN;
          cnt_d = '0;
          pin_drv_d = 1'b0;
          start_d = 1'b1;
        end
      end
      default: begin
        state_d = RSS_ST_POR;
        cnt_d = '0;
      end
    endcase
    core_rst_d = (state_d != RSS_ST_RUN);
    // gate on the next values, so no grant lingers into a reset or past a disable
    grant_d = flash_wr_req_i && vmon_en_d && !core_rst_d;
    rdata_d = 8'h00;
    if (sfr_i.rd && (sfr_i.addr == `RSS_CAUSE_ADDR)) begin
      rdata_d = {1'b0, cause_q[6:0]};
    end else if (sfr_i.rd && (sfr_i.addr == `RSS_VMON_ADDR)) begin
      rdata_d = {vmon_en_q, !src_i.vdd_low, 6'h00};
    end
  end

  // power-on loads every flop, including the monitor enables
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= RSS_ST_POR;
      cnt_q <= '0;
      cause_q <= `RSS_CAUSE_RST;
      vmon_en_q <= 1'b1;
      vmon_sel_q <= 1'b1;
      mcd_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
      pin_drv_q <= 1'b1;
      core_rst_q <= 1'b1;
      start_q <= 1'b0;
      grant_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cause_q <= cause_d;
      vmon_en_q <= vmon_en_d;
      vmon_sel_q <= vmon_sel_d;
      mcd_en_q <= mcd_en_d;
      cmp_en_q <= cmp_en_d;
      pin_drv_q <= pin_drv_d;
      core_rst_q <= core_rst_d;
      start_q <= start_d;
      grant_q <= grant_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // data memory has no reset input here, so it keeps its contents
  assign sfr_rdata_o = rdata_q;
  assign core_rst_o = core_rst_q;
  assign core_start_o = start_q;
  assign reset_vector_o = `RSS_RESET_VECTOR;
  assign port_rst_o = core_rst_q;
  assign port_latch_init_o = `RSS_PORT_RST_VAL;
  assign weak_pullup_en_o = 1'b1;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_o = pin_drv_q;
  assign flash_wr_grant_o = grant_q;
  assign vmon_en_o = vmon_en_q;
  assign mcd_en_o = mcd_en_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // pin, flash and sequencing checks, with the supply, software and watchdog causes and the clock-loss enable write
  a_pin_power_only: assert property (rst_pin_oe_o |-> core_rst_o)
    else $error("reset pin driven outside reset");
  a_pin_quiet: assert property ($rose(core_rst_o) && !cause_q[`RSS_BIT_POR]
    |-> !rst_pin_oe_o)
    else $error("pin driven by a non-power reset");
  a_vmon_hold: assert property (state_q == RSS_ST_RUN && vmon_trip
    |=> core_rst_o && rst_pin_oe_o && cause_q == 8'h02)
    else $error("supply trip did not hold reset and pin");
  a_flash_block: assert property (!vmon_en_q |-> !flash_wr_grant_o)
    else $error("flash write granted with monitor off");
  a_grant_quiet: assert property (flash_wr_grant_o |-> !core_rst_o)
    else $error("flash write granted during reset");
  a_exit_pulse: assert property ($fell(core_rst_o) |-> core_start_o
    && reset_vector_o == 16'h0000)
    else $error("missing start pulse on exit");
  a_sw_force: assert property (state_q == RSS_ST_RUN && !any_trip && cause_wr
    && sfr_i.wdata[4] |=> core_rst_o && cause_q == 8'h10)
    else $error("software reset not taken");
  a_wdt_cause: assert property (state_q == RSS_ST_RUN && !vmon_trip && !pin_trip
    && !mcd_trip && !cmp_trip && src_i.wdt_ovf |=> cause_q == 8'h08)
    else $error("watchdog cause not recorded");
  a_vmon_keep: assert property ($rose(core_rst_o) |-> $stable(vmon_en_q)
    && $stable(vmon_sel_q))
    else $error("monitor enable changed by reset");
  a_min_hold: assert property ($rose(core_rst_o) && state_q == RSS_ST_HOLD
    |-> core_rst_o [*4])
    else $error("reset shorter than minimum hold");
  a_mcd_write: assert property (state_q == RSS_ST_RUN && !any_trip && cause_wr
    && !sfr_i.wdata[4] |=> mcd_en_q == $past(sfr_i.wdata[2]))
    else $error("clock-loss enable not written");

  // cause flags of the remaining sources, each with the higher ones quiet, then hold, release and cause-register checks
  a_pin_cause: assert property (state_q == RSS_ST_RUN && !vmon_trip && pin_trip
    |=> core_rst_o && !rst_pin_oe_o && cause_q == 8'h01)
    else $error("pin reset cause not recorded");
  a_mcd_cause: assert property (state_q == RSS_ST_RUN && !vmon_trip && !pin_trip
    && mcd_trip |=> core_rst_o && cause_q == 8'h04)
    else $error("clock-loss cause not recorded");
  a_cmp_cause: assert property (state_q == RSS_ST_RUN && !vmon_trip && !pin_trip
    && !mcd_trip && cmp_trip |=> core_rst_o && cause_q == 8'h20)
    else $error("comparator cause not recorded");
  a_flash_cause: assert property (state_q == RSS_ST_RUN && !vmon_trip && !pin_trip
    && !mcd_trip && !cmp_trip && !src_i.wdt_ovf && src_i.flash_err
    |=> core_rst_o && cause_q == 8'h40)
    else $error("flash error cause not recorded");
  a_pin_hold: assert property (state_q == RSS_ST_HOLD && cause_q[`RSS_BIT_PIN]
    && !src_i.rst_pin_n |=> core_rst_o)
    else $error("pin reset released while pin low");
  a_vdd_release: assert property (state_q == RSS_ST_HOLD && cause_q[`RSS_BIT_POR]
    && cnt_q == HOLD_LAST && !src_i.vdd_low |=> !core_rst_o && core_start_o)
    else $error("supply reset not released on recovery");
  a_cause_onehot: assert property (core_start_o |-> $onehot(cause_q[6:0]))
    else $error("cause flags not one-hot on exit");
  a_reset_keeps_cause: assert property (state_q != RSS_ST_RUN |=> $stable(cause_q))
    else $error("cause changed while in reset");

  // main scenarios the bench is expected to reach
  c_vmon_reset: cover property (state_q == RSS_ST_RUN && vmon_trip ##[1:50] core_start_o);
  c_pin_reset: cover property (state_q == RSS_ST_RUN && pin_trip ##[1:50] core_start_o);
  c_sw_reset: cover property (cause_q[`RSS_BIT_SW] && core_start_o);
  c_wdt_reset: cover property (cause_q[`RSS_BIT_WDT] && core_start_o);
  c_flash_refused: cover property (flash_wr_req_i && !vmon_en_q);
endmodule
`default_nettype wire

// >>> common/rss_defines.svh
// constants of the reset source supervisor
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH
`define RSS_CAUSE_ADDR 8'hef
`define RSS_VMON_ADDR 8'hff
`define RSS_BIT_PIN 0
`define RSS_BIT_POR 1
`define RSS_BIT_MCD 2
`define RSS_BIT_WDT 3
`define RSS_BIT_SW 4
`define RSS_BIT_CMP 5
`define RSS_BIT_FLASH 6
`define RSS_BIT_VMON_EN 7
`define RSS_BIT_VDD_OK 6
`define RSS_CAUSE_RST 8'h02
`define RSS_PORT_RST_VAL 8'hff
`define RSS_RESET_VECTOR 16'h0000
`define RSS_CLK_PERIOD_NS 4
`define RSS_T_POR_NS 300000
`define RSS_POR_DELAY_CYC (`RSS_T_POR_NS / `RSS_CLK_PERIOD_NS)
`define RSS_MIN_HOLD_CYC 4
`endif

// >>> common/rss_pkg.sv
// types of the reset source supervisor
`default_nettype none
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_ST_POR = 2'b00,
    RSS_ST_RUN = 2'b01,
    RSS_ST_HOLD = 2'b10
  } rss_state_t;
  typedef struct packed {
    logic vdd_low;
    logic rst_pin_n;
    logic clk_missing;
    logic cmp0_out;
    logic wdt_ovf;
    logic flash_err;
  } rss_src_t;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rss_sfr_req_t;
endpackage
`default_nettype wire

// >>> dv/rss_src_model.sv
// far-side model: supply rail, reset pin, clock detector, comparator and fault sources
`default_nettype none
module rss_src_model
  import rss_pkg::*;
(
  input wire logic [2:0] kind_i, // source to trip, 1..6
  input wire logic fire_i, // trip request, level
  input wire logic rst_pin_oe_i, // device pulls the reset pin low
  output var rss_src_t src_o // trigger lines into the supervisor
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hit;
  always_comb begin
    hit = fire_i ? 8'(1 << kind_i) : 8'h00;
    src_o.vdd_low = hit[1];
    // pin has a pullup: it reads high unless we or the device pull it low
    src_o.rst_pin_n = !hit[2] && !rst_pin_oe_i;
    src_o.clk_missing = hit[3];
    // comparator rests high, so selecting it as a source never trips by itself
    src_o.cmp0_out = !hit[4];
    src_o.wdt_ovf = hit[5];
    src_o.flash_err = hit[6];
  end
endmodule
`default_nettype wire

// >>> dv/rss_supervisor_test.sv
// self-checking bench of the reset source supervisor
`default_nettype none
module rss_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rss_pkg::*;
  localparam int PORD = 40;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  rss_sfr_req_t special_function_register = '0;
  logic flash_req = 1'b0;
  logic [2:0] kind = 3'h0;
  logic fire = 1'b0;
  rss_src_t src;
  logic [7:0] rdata;
  logic [7:0] latch;
  logic [15:0] vec;
  logic core_rst, core_start, port_rst, weak_pu, pin_o, pin_oe, grant, vmon_en, mcd_en;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed = 32'hb375_4e90;

  always #2 core_clk_i = ~core_clk_i;

  rss_src_model u_src (.kind_i(kind), .fire_i(fire), .rst_pin_oe_i(pin_oe), .src_o(src));
  rss_supervisor #(.POR_DELAY_CYC(PORD), .MIN_HOLD_CYC(4)) u_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .src_i(src), .sfr_i(special_function_register),
    .flash_wr_req_i(flash_req), .sfr_rdata_o(rdata), .core_rst_o(core_rst),
    .core_start_o(core_start), .reset_vector_o(vec), .port_rst_o(port_rst),
    .port_latch_init_o(latch), .weak_pullup_en_o(weak_pu), .rst_pin_o(pin_o),
    .rst_pin_oe_o(pin_oe), .flash_wr_grant_o(grant), .vmon_en_o(vmon_en),
    .mcd_en_o(mcd_en));

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hang costs far more than the few hundred cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end

  // every task is entered and left just after a rising edge
  task automatic step(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    special_function_register.addr = a;
    special_function_register.wdata = d;
    special_function_register.wr = 1'b1;
    step(1);
    special_function_register.wr = 1'b0;
    // one idle edge, so a following call never re-raises the strobe in this time step
    step(1);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e, string name);
    special_function_register.addr = a;
    special_function_register.rd = 1'b1;
    step(1);
    special_function_register.rd = 1'b0;
    check(name, {8'h00, rdata}, {8'h00, e});
    step(1);
  endtask

  task automatic wait_exit(int lim, output int n);
    n = 0;
    while (core_rst === 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    check("exit", {15'h0000, core_rst}, 16'h0000);
    check("start", {15'h0000, core_start}, 16'h0001);
    step(1);
    check("start_end", {15'h0000, core_start}, 16'h0000);
  endtask

  function automatic logic [7:0] exp_cause(logic [2:0] k);
    logic [7:0] tbl [1:7];
    tbl = '{8'h02, 8'h01, 8'h04, 8'h20, 8'h08, 8'h40, 8'h10};
    return tbl[k];
  endfunction

  task automatic trip(logic [2:0] k, int hold);
    int n;
    wr(8'hff, 8'h80);
    wr(8'hef, 8'h26);
    if (k == 3'h7) begin
      wr(8'hef, 8'h10);
    end else begin
      kind = k;
      fire = 1'b1;
      step(1);
      if (k > 3'h2) begin
        fire = 1'b0;
      end
    end
    check("enter", {14'h0000, core_rst, port_rst}, 16'h0003);
    check("pin_oe", {15'h0000, pin_oe}, {15'h0000, k == 3'h1});
    if (k <= 3'h2) begin
      step(hold);
      check("held", {15'h0000, core_rst}, 16'h0001);
      fire = 1'b0;
    end
    wait_exit(8, n);
    rd(8'hef, exp_cause(k), "cause");
  endtask

  initial begin
    int n;
    logic [2:0] k;
    step(4);
    check("por_hold", {13'h0000, core_rst, pin_oe, vmon_en}, 16'h0007);
    sys_rst_i = 1'b0;
    wait_exit(PORD + 4, n);
    check("por_delay", {15'h0000, n == PORD}, 16'h0001);
    check("vector", vec, 16'h0000);
    check("ports", {latch, 6'h00, weak_pu, pin_o}, 16'hff02);
    rd(8'hef, 8'h02, "por_cause");
    rd(8'hff, 8'hc0, "monitor");
    rd(8'h55, 8'h00, "unmapped");
    wr(8'hef, 8'h26);
    rd(8'hef, 8'h02, "status_read");
    check("mcd_on", {15'h0000, mcd_en}, 16'h0001);
    wr(8'hef, 8'h02);
    check("mcd_off", {15'h0000, mcd_en}, 16'h0000);
    for (int j = 3; j <= 4; j++) begin
      kind = 3'(j);
      fire = 1'b1;
      step(3);
      fire = 1'b0;
      step(1);
      check("no_trip", {15'h0000, core_rst}, 16'h0000);
    end
    flash_req = 1'b1;
    step(2);
    check("grant_on", {15'h0000, grant}, 16'h0001);
    wr(8'hff, 8'h00);
    step(1);
    check("grant_off", {15'h0000, grant}, 16'h0000);
    wr(8'hef, 8'h10);
    wait_exit(8, n);
    check("mon_kept", {15'h0000, vmon_en}, 16'h0000);
    // a second power-on in mid-run must bring the monitor back
    sys_rst_i = 1'b1;
    step(2);
    sys_rst_i = 1'b0;
    wait_exit(PORD + 4, n);
    check("por_again", {15'h0000, n == PORD}, 16'h0001);
    rd(8'hff, 8'hc0, "monitor_again");
    rd(8'hef, 8'h02, "por_cause_again");
    for (int j = 1; j <= 7; j++) begin
      trip(3'(j), 9);
    end
    repeat (12) begin
      k = 3'(1 + {$random(seed)} % 7);
      trip(k, 1 + {$random(seed)} % 6);
    end
    flash_req = 1'b0;
    close_out();
  end
endmodule
`default_nettype wire
